// *** hw/led_pwm_pkg.sv ***
/*
  shared constants and types of the serial rgb led pwm controller:
  frame layout, register addresses, reset values and timing figures.
  assumes a single 100 mhz system clock drives every module.
*/
`default_nettype none
package led_pwm_pkg;
  // serial frame: 8 address bits below 15 data bits
  localparam int FRAME_BITS = 23;
  localparam int ADDR_BITS = 8;
  localparam int DATA_BITS = 15;
  localparam int POS_BITS = 7;
  localparam int RATE_BITS = 4;
  localparam int PRESC_BITS = 15;

  // register addresses as carried in the frame's low byte
  localparam logic [7:0] ADDR_CONTROL = 8'h0d;
  localparam logic [7:0] ADDR_RED = 8'h2d;
  localparam logic [7:0] ADDR_GREEN = 8'h4d;
  localparam logic [7:0] ADDR_BLUE = 8'h6d;

  // field positions inside the 15-bit data part
  localparam int CTRL_LSB = 0;
  localparam int CTRL_BITS = 8;
  localparam int OFF_LSB = 0;
  localparam int ON_LSB = 8;

  // channel indices inside rgb vectors
  localparam int CH_BLUE = 0;
  localparam int CH_GREEN = 1;
  localparam int CH_RED = 2;
  localparam int CHANNELS = 3;

  // timing: system clock and the internal oscillator it emulates
  localparam int CLK_PERIOD_NS = 10;
  localparam int OSC_FREQ_KHZ = 700;
  // nearest whole number of system cycles per oscillator period
  localparam int OSC_CYCLES =
    (2000000 / (CLK_PERIOD_NS * OSC_FREQ_KHZ) + 1) / 2;

  // control register, laid out as data bits 7..0
  typedef struct packed {
    logic [3:0] rate;    // divider exponent, zero bypasses
    logic red_sw;        // red channel switch
    logic green_sw;      // green channel switch
    logic blue_channel_switch;
    logic converter_enable_bit;
  } control_type;

  // per colour lighting and lights-out positions
  typedef struct packed {
    logic [6:0] on_pos;
    logic [6:0] off_pos;
  } position_type;

  // one received frame
  typedef struct packed {
    logic [14:0] data;
    logic [7:0] addr;
  } frame_type;

  // values after reset
  localparam control_type CONTROL_RESET = '0;
  localparam position_type POSITION_RESET = '0;
  localparam logic [6:0] COUNT_RESET = 7'h00;
endpackage
`default_nettype wire

// *** hw/serial_frame_receiver.sv ***
/*
  three-wire serial receiver: shift clock, data and load strobe pins.
  assumes the pins are asynchronous to clk and that the shift clock
  stays high and low for many clk periods each.
*/
`default_nettype none
module serial_frame_receiver (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sclk_pin,
  input wire logic sdata_pin,
  input wire logic strobe_pin,
  output logic [22:0] frame,
  output logic frame_valid
);
  // whole state of the receiver
  typedef struct packed {
    logic [2:0] meta;     // first synchroniser stage: sclk, data, strobe
    logic [2:0] sync;     // second synchroniser stage
    logic sclk_prev;      // delayed shift clock for edge detection
    logic stb_prev;       // delayed strobe for edge detection
    logic [22:0] buffer;  // temporary receive buffer
    logic [22:0] frame;   // frame captured at the strobe
    logic valid;          // one-cycle pulse with a new frame
  } rx_state_type;

  rx_state_type state_r;
  rx_state_type state_nxt;
  logic sclk_rise;
  logic stb_rise;

  // edges seen on the synchronised pins only
  assign sclk_rise = state_r.sync[2] & ~state_r.sclk_prev;
  assign stb_rise = state_r.sync[0] & ~state_r.stb_prev;

  // next state: synchronise, shift, capture
  always_comb begin
    state_nxt = state_r;
    state_nxt.meta = {sclk_pin, sdata_pin, strobe_pin};
    state_nxt.sync = state_r.meta;
    state_nxt.sclk_prev = state_r.sync[2];
    state_nxt.stb_prev = state_r.sync[0];
    state_nxt.valid = 1'b0;
    // data goes in at the bottom, first bit ends up on top
    if (sclk_rise) begin
      state_nxt.buffer = {state_r.buffer[21:0], state_r.sync[1]};
    end
    // buffer contents matter only from a strobe onward
    if (stb_rise) begin
      state_nxt.frame = state_r.buffer;
      state_nxt.valid = 1'b1;
    end
  end

  // register the state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign frame = state_r.frame;
  assign frame_valid = state_r.valid;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  // a shift clock edge moves the buffer up by one bit
  property p_shift_in;
    sclk_rise |=> state_r.buffer == {$past(state_r.buffer[21:0]), $past(state_r.sync[1])};
  endproperty
  a_shift_in: assert property (p_shift_in) else $error("buffer did not shift");

  // without a strobe no frame is announced
  property p_no_frame_without_strobe;
    !stb_rise |=> !frame_valid;
  endproperty
  a_no_frame_without_strobe: assert property (p_no_frame_without_strobe)
    else $error("frame announced without strobe");
endmodule
`default_nettype wire

// *** hw/pwm_channel.sv ***
/*
  one colour channel: compares the shared position counter with the
  channel's lighting and lights-out positions and drives the enable of
  its open-drain output. assumes count and settings are on clk.
*/
`default_nettype none
module pwm_channel #(
  parameter int POS_W = 7
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic active,
  input wire logic switch_on,
  input wire logic [POS_W-1:0] on_pos,
  input wire logic [POS_W-1:0] off_pos,
  input wire logic [POS_W-1:0] count,
  output logic sink_en
);
  // whole state of the channel
  typedef struct packed {
    logic sink;  // high while the pin pulls the cathode low
  } ch_state_type;

  ch_state_type state_r;
  ch_state_type state_nxt;
  logic in_window;

  // lit from the on position up to just before the off position,
  // always lit when both are equal
  assign in_window = (on_pos == off_pos) || (count >= on_pos && count < off_pos);

  // switch off or standby leaves the pin floating
  always_comb begin
    state_nxt = state_r;
    state_nxt.sink = active & switch_on & in_window;
  end

  // register the state, floating after reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign sink_en = state_r.sink;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  // switch off forces the pin to float on the next edge
  property p_switch_off_float;
    !switch_on |=> !sink_en;
  endproperty
  a_switch_off_float: assert property (p_switch_off_float)
    else $error("pin driven with switch off");
endmodule
`default_nettype wire

// *** hw/led_rgb_pwm_top.sv ***
/*
  three-colour led pwm controller loaded over a serial write port.
  holds the control and position registers, the oscillator emulation,
  the programmable divider and the 7-bit position counter.
  assumes every pin input is asynchronous and that led pins are wired
  open-drain outside, the enable low meaning high impedance.
*/
`default_nettype none
module led_rgb_pwm_top #(
  parameter int POS_W = 7
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sclk_pin,
  input wire logic sdata_pin,
  input wire logic load_strobe,
  input wire logic chip_reset_low,
  input wire logic standby_request_n,
  output logic [2:0] led_o,
  output logic [2:0] led_oe,
  output logic boost_output,
  output logic standby_active
);
  // whole state of the controller
  typedef struct packed {
    logic rst_meta;                 // reset pin, first stage
    logic rst_sync;                 // reset pin, second stage
    logic stby_meta;                // standby pin, first stage
    logic stby_sync;                // standby pin, second stage
    led_pwm_pkg::control_type ctrl; // control register
    led_pwm_pkg::position_type [2:0] pos; // colour registers
    logic [7:0] osc_cnt;            // oscillator period counter
    logic osc_tick;                 // one pulse per oscillator period
    logic [14:0] presc;             // programmable divider
    logic base_tick;                // one pulse per pwm base period
    logic [6:0] count;              // pwm position counter
    logic standby;                  // registered standby condition
    logic [2:0] led_o;              // open-drain drive level, always low
    logic boost;                    // converter running
  } top_state_type;

  top_state_type state_r;
  top_state_type state_nxt;
  led_pwm_pkg::frame_type frame;
  logic [22:0] frame_bits;
  logic frame_valid;
  logic in_reset;
  logic standby_now;
  logic [14:0] presc_mask;
  logic [7:0] frame_ctrl;
  led_pwm_pkg::position_type frame_pos;
  logic [2:0] sink_en;

  // serial port keeps running in standby
  serial_frame_receiver u_rx (
    .clk(clk),
    .rst_n(rst_n),
    .sclk_pin(sclk_pin),
    .sdata_pin(sdata_pin),
    .strobe_pin(load_strobe),
    .frame(frame_bits),
    .frame_valid(frame_valid)
  );

  // low byte address, upper bits data
  assign frame = led_pwm_pkg::frame_type'(frame_bits);
  assign frame_ctrl = frame.data[led_pwm_pkg::CTRL_LSB +: led_pwm_pkg::CTRL_BITS];
  assign frame_pos.on_pos = frame.data[led_pwm_pkg::ON_LSB +: led_pwm_pkg::POS_BITS];
  assign frame_pos.off_pos = frame.data[led_pwm_pkg::OFF_LSB +: led_pwm_pkg::POS_BITS];

  // reset pin low holds everything but the serial receiver in reset
  assign in_reset = ~state_r.rst_sync;

  // standby from reset, standby pin or converter bit
  assign standby_now = in_reset | ~state_r.stby_sync | ~state_r.ctrl.converter_enable_bit;

  // divider wraps after two to the rate oscillator periods
  assign presc_mask = 15'((16'h0001 << state_r.ctrl.rate) - 16'h0001);

  // next-state logic of the whole controller
  always_comb begin
    state_nxt = state_r;
    // pin synchronisers
    state_nxt.rst_meta = chip_reset_low;
    state_nxt.rst_sync = state_r.rst_meta;
    state_nxt.stby_meta = standby_request_n;
    state_nxt.stby_sync = state_r.stby_meta;
    state_nxt.standby = standby_now;
    state_nxt.led_o = 3'h0;

    // register loads
    if (in_reset) begin
      // back to initial values
      state_nxt.ctrl = led_pwm_pkg::CONTROL_RESET;
      state_nxt.pos = {3{led_pwm_pkg::POSITION_RESET}};
    end else if (frame_valid) begin
      // decode the captured address
      unique case (frame.addr)
        led_pwm_pkg::ADDR_CONTROL: begin
          state_nxt.ctrl = led_pwm_pkg::control_type'(frame_ctrl);
        end
        led_pwm_pkg::ADDR_RED: begin
          state_nxt.pos[led_pwm_pkg::CH_RED] = frame_pos;
        end
        led_pwm_pkg::ADDR_GREEN: begin
          state_nxt.pos[led_pwm_pkg::CH_GREEN] = frame_pos;
        end
        led_pwm_pkg::ADDR_BLUE: begin
          state_nxt.pos[led_pwm_pkg::CH_BLUE] = frame_pos;
        end
        default: begin
          // unknown address, nothing moves
        end
      endcase
    end

    // oscillator, stopped in standby
    if (standby_now) begin
      state_nxt.osc_cnt = 8'h00;
      state_nxt.osc_tick = 1'b0;
    end else if (state_r.osc_cnt == 8'(led_pwm_pkg::OSC_CYCLES - 1)) begin
      state_nxt.osc_cnt = 8'h00;
      state_nxt.osc_tick = 1'b1;
    end else begin
      state_nxt.osc_cnt = state_r.osc_cnt + 8'h01;
      state_nxt.osc_tick = 1'b0;
    end

    // converter follows the oscillator
    state_nxt.boost = ~standby_now;

    // programmable divider
    state_nxt.base_tick = 1'b0;
    if (standby_now) begin
      state_nxt.presc = 15'h0000;
    end else if (state_r.osc_tick) begin
      if (state_r.ctrl.rate == 4'h0) begin
        // bypass: every oscillator period
        state_nxt.base_tick = 1'b1;
      end else if (state_r.presc == presc_mask) begin
        state_nxt.presc = 15'h0000;
        state_nxt.base_tick = 1'b1;
      end else begin
        state_nxt.presc = state_r.presc + 15'h0001;
      end
    end

    // position counter, cleared in standby
    if (standby_now) begin
      state_nxt.count = led_pwm_pkg::COUNT_RESET;
    end else if (state_r.base_tick) begin
      // wraps after 128 positions
      state_nxt.count = state_r.count + 7'h01;
    end
  end

  // register the state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  // one comparator per colour
  for (genvar ch = 0; ch < led_pwm_pkg::CHANNELS; ch++) begin : g_ch
    logic sw;
    if (ch == led_pwm_pkg::CH_RED) begin : g_r
      assign sw = state_r.ctrl.red_sw;
    end else if (ch == led_pwm_pkg::CH_GREEN) begin : g_g
      assign sw = state_r.ctrl.green_sw;
    end else begin : g_b
      assign sw = state_r.ctrl.blue_channel_switch;
    end
    pwm_channel #(.POS_W(POS_W)) u_ch (
      .clk(clk),
      .rst_n(rst_n),
      .active(~state_r.standby),
      .switch_on(sw),
      .on_pos(state_r.pos[ch].on_pos),
      .off_pos(state_r.pos[ch].off_pos),
      .count(state_r.count),
      .sink_en(sink_en[ch])
    );
  end

  // open-drain pins only ever pull low
  assign led_o = state_r.led_o;
  assign led_oe = sink_en;
  assign boost_output = state_r.boost;
  assign standby_active = state_r.standby;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  // a control write lands in the control register
  sequence s_ctrl_write;
    frame_valid && frame.addr == led_pwm_pkg::ADDR_CONTROL && !in_reset;
  endsequence
  property p_ctrl_write;
    s_ctrl_write |=> state_r.ctrl == $past(frame_ctrl);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost");

  // reset returns registers to their initial values
  property p_reset_regs;
    in_reset |=> state_r.ctrl == '0 && state_r.pos == '0;
  endproperty
  a_reset_regs: assert property (p_reset_regs) else $error("registers not reset");

  // reset and a disabled converter both mean standby
  property p_reset_standby;
    (in_reset || !state_r.ctrl.converter_enable_bit) |=> standby_active;
  endproperty
  a_reset_standby: assert property (p_reset_standby) else $error("no standby");

  // counter halted at zero in standby, steps on a base pulse otherwise
  property p_count_step;
    state_r.base_tick && !standby_now |=> state_r.count == $past(state_r.count) + 7'h01;
  endproperty
  a_count_step: assert property (p_count_step) else $error("counter did not step");

  property p_count_clear;
    standby_now |=> state_r.count == 7'h00;
  endproperty
  a_count_clear: assert property (p_count_clear) else $error("counter not cleared");

  // standby floats all three pins two edges later
  sequence s_held_standby;
    standby_now [*2];
  endsequence
  property p_standby_dark;
    s_held_standby |=> led_oe == 3'h0;
  endproperty
  a_standby_dark: assert property (p_standby_dark) else $error("led lit in standby");

  // oscillator and converter stop in standby
  property p_osc_stop;
    standby_now |=> !state_r.osc_tick && !boost_output;
  endproperty
  a_osc_stop: assert property (p_osc_stop) else $error("oscillator ran in standby");

  // synchronised standby pin low forces standby
  property p_pin_standby;
    !state_r.stby_sync |=> standby_active;
  endproperty
  a_pin_standby: assert property (p_pin_standby) else $error("pin standby ignored");

  // an unknown address leaves every register as it was
  property p_unmapped;
    frame_valid && !in_reset && frame.addr != led_pwm_pkg::ADDR_CONTROL &&
      frame.addr != led_pwm_pkg::ADDR_RED && frame.addr != led_pwm_pkg::ADDR_GREEN &&
      frame.addr != led_pwm_pkg::ADDR_BLUE |=> $stable(state_r.ctrl) && $stable(state_r.pos);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped write changed state");

  // open-drain level never high
  property p_drive_low;
    led_o == 3'h0;
  endproperty
  a_drive_low: assert property (p_drive_low) else $error("led driven high");

  // colour writes land in standby too, except while the reset pin is held low
  sequence s_red_write;
    frame_valid && frame.addr == led_pwm_pkg::ADDR_RED && !in_reset;
  endsequence
  property p_red_write;
    s_red_write |=> state_r.pos[led_pwm_pkg::CH_RED] == $past(frame_pos);
  endproperty
  a_red_write: assert property (p_red_write)
    else $error("colour write lost");

  // rate zero passes every oscillator pulse straight through
  property p_bypass_tick;
    state_r.osc_tick && state_r.ctrl.rate == 4'h0 && !standby_now |=> state_r.base_tick;
  endproperty
  a_bypass_tick: assert property (p_bypass_tick)
    else $error("bypass tick missing");

  // base pulses only ever follow an oscillator pulse
  property p_tick_source;
    state_r.base_tick |-> $past(state_r.osc_tick);
  endproperty
  a_tick_source: assert property (p_tick_source)
    else $error("base tick without oscillator");

  // converter runs whenever the device is out of standby
  property p_boost_run;
    !standby_now |=> boost_output;
  endproperty
  a_boost_run: assert property (p_boost_run)
    else $error("converter idle outside standby");
endmodule
`default_nettype wire

// *** tb/host_serial_model.sv ***
/*
  host cpu model: sends 23-bit write frames on the shift clock, data
  and load strobe pins with wide margins on every timing limit.
  assumes clk is the 100 mhz bench clock, used only to pace the pins.
*/
`default_nettype none
module host_serial_model (
  input wire logic clk,
  output logic sclk_pin,
  output logic sdata_pin,
  output logic load_strobe
);
  timeunit 1ns;
  timeprecision 100ps;

  // shift clock rests low between frames
  initial begin
    sclk_pin = 1'b0;
    sdata_pin = 1'b0;
    load_strobe = 1'b0;
  end

  // pins move 1 ns after a rising clk edge
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // one write frame, most significant bit first
  task automatic send_frame(input logic [7:0] addr, input logic [14:0] data);
    logic [22:0] f;
    f = {data, addr};
    for (int i = 22; i >= 0; i--) begin
      sdata_pin = f[i];
      wait_cyc(25); // 250 ns low phase
      sclk_pin = 1'b1;
      wait_cyc(25); // 250 ns high phase
      sclk_pin = 1'b0;
    end
    // data released: show the inverse rather than the last bit
    sdata_pin = ~f[0];
    wait_cyc(20);
    load_strobe = 1'b1;
    wait_cyc(15); // strobe high 150 ns
    load_strobe = 1'b0;
    wait_cyc(50); // 500 ns before any next shift edge
  endtask
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
/*
  self-checking bench of the led pwm controller top: reset, control
  writes, bad address, duty counts at two rates, standby and chip reset.
  assumes the host model owns the serial pins and clk runs at 100 mhz.
*/
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int OSC = led_pwm_pkg::OSC_CYCLES; // clk cycles per oscillator tick
  localparam int LAP = 128 * OSC; // one counter lap at rate 0

  logic clk = 1'b0; // system clock
  logic rst_n = 1'b0; // bench reset
  logic chip_reset_low = 1'b1; // reset pin, released
  logic standby_request_n = 1'b1; // standby pin, normal
  wire logic sclk_pin; // serial shift clock
  wire logic sdata_pin; // serial data
  wire logic load_strobe; // serial strobe
  logic [2:0] led_o; // open-drain levels
  logic [2:0] led_oe; // open-drain enables
  logic boost_output; // converter running
  logic standby_active; // standby flag
  wire logic [7:0] pins = {led_o, led_oe, boost_output, standby_active};
  int bad_count = 0;
  int n_tests = 0;
  int r;
  int g;
  int b;

  // 10 ns period
  always #5 clk = ~clk;

  led_rgb_pwm_top dut (
    .clk(clk),
    .rst_n(rst_n),
    .sclk_pin(sclk_pin),
    .sdata_pin(sdata_pin),
    .load_strobe(load_strobe),
    .chip_reset_low(chip_reset_low),
    .standby_request_n(standby_request_n),
    .led_o(led_o),
    .led_oe(led_oe),
    .boost_output(boost_output),
    .standby_active(standby_active)
  );

  host_serial_model host (
    .clk(clk),
    .sclk_pin(sclk_pin),
    .sdata_pin(sdata_pin),
    .load_strobe(load_strobe)
  );

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // one comparison, counted, and reported at once on a mismatch
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // control frame: switches given as red, green, blue, converter
  task automatic ctrl(input logic [3:0] rate, input logic [3:0] sw);
    host.send_frame(led_pwm_pkg::ADDR_CONTROL, {7'h00, rate, sw});
  endtask

  // colour frame: on position above a don't-care bit above off position
  task automatic pos(input logic [7:0] addr, input logic [6:0] on, input logic [6:0] off);
    host.send_frame(addr, {on, 1'b0, off});
  endtask

  // lit cycles of each colour over n cycles
  task automatic lit(input int n);
    r = 0;
    g = 0;
    b = 0;
    repeat (n) begin
      cyc(1);
      if (led_oe[led_pwm_pkg::CH_RED] === 1'b1) r++;
      if (led_oe[led_pwm_pkg::CH_GREEN] === 1'b1) g++;
      if (led_oe[led_pwm_pkg::CH_BLUE] === 1'b1) b++;
    end
  endtask

  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // reset values: dark, floating, converter off, standby
  task automatic t_reset();
    cyc(3);
    chk(16'(pins), 16'h01, "after reset");
  endtask

  // enable all: positions 0/0 give full duty, bad address changes nothing
  task automatic t_enable();
    ctrl(4'h0, 4'hf);
    cyc(4);
    chk(16'(pins), 16'h1e, "all on");
    host.send_frame(8'h0e, 15'h0000);
    cyc(4);
    chk(16'(pins), 16'h1e, "unknown address");
  endtask

  // duty over whole laps at rate 0 and rate 1, green switched off
  task automatic t_duty();
    pos(led_pwm_pkg::ADDR_RED, 7'd0, 7'd5);
    pos(led_pwm_pkg::ADDR_GREEN, 7'd10, 7'd20);
    pos(led_pwm_pkg::ADDR_BLUE, 7'd0, 7'd127);
    ctrl(4'h0, 4'b1011);
    lit(LAP);
    chk(16'(r), 16'(5 * OSC), "red duty");
    chk(16'(g), 16'h0, "green off");
    chk(16'(b), 16'(127 * OSC), "blue duty");
    // pass through standby so divider and counter restart clean
    ctrl(4'h1, 4'b1010);
    ctrl(4'h1, 4'b1011);
    lit(2 * LAP);
    chk(16'(r), 16'(10 * OSC), "red duty rate 1");
  endtask

  // standby pin: dark and stopped, writes still taken, counter restarts
  task automatic t_standby();
    pos(led_pwm_pkg::ADDR_RED, 7'd0, 7'd1);
    ctrl(4'h0, 4'b1001);
    // short standby pulse puts the counter at a known position
    standby_request_n = 1'b0;
    cyc(4);
    standby_request_n = 1'b1;
    cyc(3 * OSC);
    chk(16'(pins), 16'h02, "red past its window");
    standby_request_n = 1'b0;
    cyc(8);
    chk(16'(pins), 16'h01, "standby pin");
    pos(led_pwm_pkg::ADDR_GREEN, 7'd3, 7'd3);
    ctrl(4'h0, 4'b1101);
    chk(16'(pins), 16'h01, "write in standby");
    standby_request_n = 1'b1;
    cyc(8);
    chk(16'(pins), 16'h1a, "restart at zero");
  endtask

  // chip reset pin clears registers and leaves the device in standby
  task automatic t_chip_reset();
    chip_reset_low = 1'b0;
    cyc(8);
    chk(16'(pins), 16'h01, "chip reset held");
    chip_reset_low = 1'b1;
    cyc(8);
    chk(16'(pins), 16'h01, "after chip reset");
    ctrl(4'h0, 4'hf);
    cyc(4);
    chk(16'(pins), 16'h1e, "positions cleared");
  endtask

  initial begin
    repeat (16) @(posedge clk);
    #1;
    rst_n = 1'b1;
    t_reset();
    t_enable();
    t_duty();
    t_standby();
    t_chip_reset();
    print_verdict();
  end

  // guard against a hang
  initial begin
    repeat (95000) @(posedge clk);
    bad_count++;
    $display("mismatch at %0t: run did not finish", $time);
    print_verdict();
  end
endmodule
`default_nettype wire
